//--- bench/frame_trailer_inserter_tb_top.sv
// Purpose: register access and two full trailers checked octet by octet
// Assumes: source model answers one cycle after each address
// Notes: second trailer runs with the serial output disabled
`timescale 1ns/1ns
`define CHECK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module frame_trailer_inserter_tb_top;
    import trailer_pkg::*;
    logic i_clock = 1'b0, i_rst_n = 1'b0, i_frame_end = 1'b0, i_par_en = 1'b0, i_ser_en = 1'b0;
    logic [7:0] i_hist_data, i_ext_data, i_wdata = 8'h00, o_rdata, o_data, rd_val;
    logic [15:0] i_addr = 16'h0000;
    logic i_wr = 1'b0, i_rd = 1'b0, o_hist_req, o_ext_req, o_par_valid, o_ser_valid, o_first, o_last;
    logic [9:0] o_hist_addr, o_ext_slot;
    int error_cnt = 0, samples_checked = 0;
    always #4 i_clock = ~i_clock;
    frame_trailer_inserter dut_u (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_frame_end(i_frame_end),
        .i_par_en(i_par_en), .i_ser_en(i_ser_en), .i_hist_data(i_hist_data), .i_ext_data(i_ext_data),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_hist_req(o_hist_req), .o_hist_addr(o_hist_addr), .o_ext_req(o_ext_req), .o_ext_slot(o_ext_slot),
        .o_data(o_data), .o_par_valid(o_par_valid), .o_ser_valid(o_ser_valid), .o_first(o_first),
        .o_last(o_last));
    trailer_source_model src_u (.i_clock(i_clock), .i_hist_req(o_hist_req), .i_hist_addr(o_hist_addr),
        .i_ext_req(o_ext_req), .i_ext_slot(o_ext_slot), .o_hist_data(i_hist_data), .o_ext_data(i_ext_data));
    task automatic end_of_test;
        $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask : rd
    function automatic logic [7:0] exp_octet(input int idx, input logic [31:0] cnt, input logic [7:0] ori);
        logic [9:0] k;
        k = idx[9:0];
        if (idx < 1024) return k[7:0] ^ {k[9:8], 6'h2a};
        if (idx < 1028) return cnt[8*(1027-idx) +: 8];
        k = 10'(idx - 1026);
        case (k)
            SLOT_ORIENT: return ori;
            SLOT_IRQ: return 8'ha7;
            SLOT_TPM: return 8'h09;
            SLOT_PROT: return PROT_UNLOCK;
            default: return k[7:0] + 8'h3c;
        endcase
    endfunction : exp_octet
    task automatic run_frame(input logic [31:0] cnt, input logic [7:0] ori, input logic ser);
        int n;
        @(posedge i_clock);
        i_frame_end <= 1'b1;
        i_par_en <= 1'b1;
        i_ser_en <= ser;
        i_addr <= ADDR_ORIENT;
        i_wdata <= 8'h01;
        n = 0;
        do begin
            @(posedge i_clock);
            i_frame_end <= 1'b0;
            #1 n++;
        end while (o_first !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            return;
        end
        `CHECK(n, START_LATENCY)
        for (int i = 0; i < 1397; i++) begin
            `CHECK(o_data, exp_octet(i, cnt, ori))
            `CHECK({o_par_valid, o_ser_valid, o_first, o_last}, {1'b1, ser, i == 0, i == 1396})
            @(posedge i_clock);
            i_frame_end <= (i == 500);
            i_wr <= (i == 500);
            #1;
        end
        repeat (5) @(posedge i_clock);
        #1 `CHECK({o_par_valid, o_ser_valid, o_hist_req}, 3'h0)
    endtask : run_frame
    initial begin
        repeat (10) @(posedge i_clock);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_clock);
        rd(ADDR_ORIENT, rd_val);
        `CHECK(rd_val, 8'h00)
        wr(ADDR_ORIENT, 8'h03);
        wr(ADDR_IRQ, 8'ha7);
        wr(ADDR_TPM, 8'h05);
        rd(ADDR_TPM, rd_val);
        `CHECK(rd_val, 8'h00)
        wr(ADDR_PROT, PROT_UNLOCK);
        wr(ADDR_TPM, 8'h09);
        wr(16'h1234, 8'hff);
        rd(ADDR_TPM, rd_val);
        `CHECK(rd_val, 8'h09)
        rd(ADDR_PROT, rd_val);
        `CHECK(rd_val, PROT_UNLOCK)
        rd(ADDR_IRQ, rd_val);
        `CHECK(rd_val, 8'ha7)
        rd(16'h1234, rd_val);
        `CHECK(rd_val, 8'h00)
        run_frame(32'h0, 8'h03, 1'b1);
        rd(ADDR_ORIENT, rd_val);
        `CHECK(rd_val, 8'h01)
        run_frame(32'h1, 8'h01, 1'b0);
        rd(ADDR_FCOUNT, rd_val);
        `CHECK(rd_val, 8'h02)
        end_of_test();
    end
endmodule : frame_trailer_inserter_tb_top

//--- bench/trailer_source_model.sv
// Purpose: histogram memory and external slot source answering the trailer inserter
// Assumes: one cycle read latency, contents fixed per address
// Notes: outputs toggle to the inverse of the last value when not addressed
`timescale 1ns/1ns
module trailer_source_model (
    input wire logic i_clock,
    input wire logic i_hist_req,
    input wire logic [9:0] i_hist_addr,
    input wire logic i_ext_req,
    input wire logic [9:0] i_ext_slot,
    output logic [7:0] o_hist_data,
    output logic [7:0] o_ext_data
);
    initial begin
        o_hist_data = 8'h00;
        o_ext_data = 8'h00;
    end
    always @(posedge i_clock) begin
        if (i_hist_req) begin
            o_hist_data <= i_hist_addr[7:0] ^ {i_hist_addr[9:8], 6'h2a};
        end else begin
            o_hist_data <= ~o_hist_data;
        end
        if (i_ext_req) begin
            o_ext_data <= i_ext_slot[7:0] + 8'h3c;
        end else begin
            o_ext_data <= ~o_ext_data;
        end
    end
endmodule : trailer_source_model

//--- hdl/frame_trailer_inserter.sv
// Purpose: emits the per-frame trailer octet stream to the parallel and serial outputs
// Assumes: histogram and external slot sources answer one cycle after address
// Notes: frame end while a trailer is still running is ignored
`timescale 1ns/1ns
module frame_trailer_inserter (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_frame_end,
    input wire logic i_par_en,
    input wire logic i_ser_en,
    input wire logic [7:0] i_hist_data,
    input wire logic [7:0] i_ext_data,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_hist_req,
    output logic [9:0] o_hist_addr,
    output logic o_ext_req,
    output logic [9:0] o_ext_slot,
    output logic [7:0] o_data,
    output logic o_par_valid,
    output logic o_ser_valid,
    output logic o_first,
    output logic o_last
);
    import trailer_pkg::*;

    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [1:0] orient_q;
    logic [7:0] irq_q;
    logic [3:0] tpm_q;
    logic [7:0] prot_q;
    logic [31:0] fcount_q;
    logic [1:0] sh_orient_q;
    logic [7:0] sh_irq_q;
    logic [3:0] sh_tpm_q;
    logic [7:0] sh_prot_q;
    logic [31:0] sh_count_q;
    logic [7:0] rdata_q;
    phase_t phase_q;
    phase_t phase_d;
    logic [9:0] idx_q;
    logic [9:0] idx_d;
    logic hist_req_q;
    logic ext_req_q;
    logic start;
    logic s1_valid_q;
    logic s1_first_q;
    logic s1_last_q;
    src_t s1_src_q;
    logic [7:0] s1_byte_q;
    logic par_en_q;
    logic ser_en_q;
    logic tr_valid_q;
    logic tr_first_q;
    logic tr_last_q;
    logic par_valid_q;
    logic ser_valid_q;
    logic [7:0] data_q;
    logic [10:0] tr_pos_q;
    logic [8:0] own;

    function automatic logic [8:0] own_slot(input logic [9:0] slot, input logic [1:0] orient,
                                            input logic [7:0] irq, input logic [3:0] tpm,
                                            input logic [7:0] prot);
        case (slot)
            SLOT_ORIENT: own_slot = {1'b1, 6'h00, orient};
            SLOT_IRQ: own_slot = {1'b1, irq};
            SLOT_TPM: own_slot = {1'b1, 4'h0, tpm};
            SLOT_PROT: own_slot = {1'b1, prot};
            default: own_slot = 9'h000;
        endcase
    endfunction : own_slot

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!rst_n);

    // new trailer only when the sequencer is idle and stage 1 has drained
    assign start = i_frame_end && (phase_q == PH_IDLE) && !s1_valid_q;  // see [R2]

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            orient_q <= ORIENT_RESET;
            irq_q <= IRQ_RESET;
            tpm_q <= TPM_RESET;
            prot_q <= PROT_RESET;
        end else if (i_wr) begin
            if (i_addr == ADDR_ORIENT) begin
                orient_q <= i_wdata[1:0];
            end
            if (i_addr == ADDR_IRQ) begin
                irq_q <= i_wdata;
            end
            if (i_addr == ADDR_TPM && prot_q == PROT_UNLOCK) begin  // see [R8]
                tpm_q <= i_wdata[3:0];
            end
            if (i_addr == ADDR_PROT) begin
                prot_q <= i_wdata;
            end
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (!i_rd) begin
            rdata_q <= 8'h00;
        end else begin
            unique case (i_addr)
                ADDR_FCOUNT: rdata_q <= fcount_q[7:0];
                ADDR_ORIENT: rdata_q <= {6'h00, orient_q};
                ADDR_IRQ: rdata_q <= irq_q;
                ADDR_TPM: rdata_q <= {4'h0, tpm_q};
                ADDR_PROT: rdata_q <= prot_q;
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    // snapshot of the frame count and registers the trailer reports, taken once per frame
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            fcount_q <= FCOUNT_RESET;
            sh_count_q <= FCOUNT_RESET;
            sh_orient_q <= ORIENT_RESET;
            sh_irq_q <= IRQ_RESET;
            sh_tpm_q <= TPM_RESET;
            sh_prot_q <= PROT_RESET;
        end else if (start) begin  // see [R10]
            fcount_q <= fcount_q + 32'h0000_0001;
            sh_count_q <= fcount_q;
            sh_orient_q <= orient_q;
            sh_irq_q <= irq_q;
            sh_tpm_q <= tpm_q;
            sh_prot_q <= prot_q;
        end
    end

    always_comb begin
        phase_d = phase_q;
        idx_d = idx_q;
        unique case (phase_q)
            PH_IDLE: begin
                if (start) begin
                    phase_d = PH_HIST;
                    idx_d = 10'h000;
                end
            end
            PH_HIST: begin  // see [R3]
                if (idx_q == HIST_LAST_IDX) begin
                    phase_d = PH_COUNT;
                    idx_d = 10'h000;
                end else begin
                    idx_d = idx_q + 10'h001;
                end
            end
            PH_COUNT: begin  // see [R4]
                if (idx_q == COUNT_LAST_IDX) begin
                    phase_d = PH_SLOTS;
                    idx_d = FIRST_REG_SLOT;
                end else begin
                    idx_d = idx_q + 10'h001;
                end
            end
            PH_SLOTS: begin  // see [R5]
                if (idx_q == LAST_SLOT) begin
                    phase_d = PH_IDLE;
                    idx_d = 10'h000;
                end else begin
                    idx_d = idx_q + 10'h001;
                end
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= PH_IDLE;
            idx_q <= 10'h000;
            hist_req_q <= 1'b0;
            ext_req_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            idx_q <= idx_d;
            hist_req_q <= (phase_d == PH_HIST);
            ext_req_q <= (phase_d == PH_SLOTS);
        end
    end

    assign own = own_slot(idx_q, sh_orient_q, sh_irq_q, sh_tpm_q, sh_prot_q);

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            s1_valid_q <= 1'b0;
            s1_first_q <= 1'b0;
            s1_last_q <= 1'b0;
            s1_src_q <= SRC_HIST;
            s1_byte_q <= 8'h00;
        end else begin
            s1_valid_q <= (phase_q != PH_IDLE);
            s1_first_q <= (phase_q == PH_HIST) && (idx_q == 10'h000);
            s1_last_q <= (phase_q == PH_SLOTS) && (idx_q == LAST_SLOT);
            s1_byte_q <= 8'h00;
            s1_src_q <= SRC_HIST;
            if (phase_q == PH_COUNT) begin
                s1_src_q <= SRC_LOCAL;
                s1_byte_q <= sh_count_q[8 * (3 - idx_q[1:0]) +: 8];  // see [R9]
            end else if (phase_q == PH_SLOTS) begin
                s1_src_q <= own[8] ? SRC_LOCAL : SRC_EXT;
                s1_byte_q <= own[7:0];  // see [R6] [R7]
            end
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            par_en_q <= 1'b0;
            ser_en_q <= 1'b0;
        end else if (start) begin
            par_en_q <= i_par_en;
            ser_en_q <= i_ser_en;
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            tr_valid_q <= 1'b0;
            tr_first_q <= 1'b0;
            tr_last_q <= 1'b0;
            par_valid_q <= 1'b0;
            ser_valid_q <= 1'b0;
            data_q <= 8'h00;
            tr_pos_q <= 11'h000;
        end else begin
            tr_valid_q <= s1_valid_q;
            tr_first_q <= s1_first_q;
            tr_last_q <= s1_last_q;
            par_valid_q <= s1_valid_q && par_en_q;  // see [R1]
            ser_valid_q <= s1_valid_q && ser_en_q;  // see [R1]
            unique case (s1_src_q)
                SRC_HIST: data_q <= i_hist_data;
                SRC_EXT: data_q <= i_ext_data;
                default: data_q <= s1_byte_q;
            endcase
            if (s1_first_q) begin
                tr_pos_q <= 11'h000;
            end else if (s1_valid_q) begin
                tr_pos_q <= tr_pos_q + 11'h001;
            end
        end
    end

    assign o_rdata = rdata_q;
    assign o_hist_req = hist_req_q;
    assign o_hist_addr = idx_q;
    assign o_ext_req = ext_req_q;
    assign o_ext_slot = idx_q;
    assign o_data = data_q;
    assign o_par_valid = par_valid_q;
    assign o_ser_valid = ser_valid_q;
    assign o_first = tr_first_q;
    assign o_last = tr_last_q;

    sequence count_bytes_seq;
        (data_q == sh_count_q[31:24]) ##1 (data_q == sh_count_q[23:16])
            ##1 (data_q == sh_count_q[15:8]) ##1 (data_q == sh_count_q[7:0]);
    endsequence

    chk_outputs_alike: assert property ((par_valid_q || ser_valid_q) |-> tr_valid_q && // see [R1]
        (par_valid_q == par_en_q) && (ser_valid_q == ser_en_q)) else $error("output valid mismatch");
    chk_start_latency: assert property (start |-> ##START_LATENCY (tr_valid_q && tr_first_q)) // see [R2]
        else $error("trailer did not start on time");
    chk_hist_passthru: assert property ((tr_valid_q && tr_pos_q < POS_COUNT) |-> // see [R3]
        (data_q == $past(i_hist_data))) else $error("histogram octet wrong");
    chk_count_order: assert property ((tr_valid_q && tr_pos_q == POS_COUNT) |-> count_bytes_seq) // see [R4] [R9]
        else $error("frame count octets wrong");
    chk_trailer_length: assert property (tr_last_q |-> (tr_pos_q == POS_LAST) ##1 !tr_valid_q) // see [R5]
        else $error("trailer length wrong");
    chk_orient_slot: assert property ((tr_valid_q && tr_pos_q == POS_ORIENT) |-> // see [R6]
        (data_q == {6'h00, sh_orient_q})) else $error("orientation slot wrong");
    chk_irq_slot: assert property ((tr_valid_q && tr_pos_q == POS_IRQ) |-> (data_q == sh_irq_q)) // see [R7]
        else $error("interrupt control slot wrong");
    chk_tp_protect: assert property ((i_wr && i_addr == ADDR_TPM && prot_q != PROT_UNLOCK) |=> // see [R8]
        $stable(tpm_q)) else $error("protected write took effect");
    chk_snapshot_hold: assert property ((phase_q != PH_IDLE || s1_valid_q) |=> // see [R10]
        ($stable(sh_count_q) && $stable(sh_irq_q) && $stable(sh_orient_q))) else $error("snapshot changed");
endmodule : frame_trailer_inserter

//--- pkg/trailer_pkg.sv
// Purpose: constants and types for the frame trailer inserter
// Assumes: one octet of trailer per clock, no back-pressure from the outputs
// Notes: trailer = histogram, then slot 1 (4-octet frame count), then slots 2..last
// Summary of operation
// [R1] same trailer on every enabled video output
// [R2] trailer follows last active image line
// [R3] trailer carries 1024-octet image histogram
// [R4] frame counter occupies exactly four octets
// [R5] register snapshot in ascending slot order
// [R6] orientation slot: bit0 mirror, bit1 flip
// [R7] interrupt slot: array bits 2:0, timing 7:3
// [R8] test pattern write needs protection unlocked
// [R9] multi-byte values most significant byte first
// [R10] all trailer values sampled for one frame
package trailer_pkg;
    localparam int HIST_BYTES = 1024;
    localparam int COUNT_BYTES = 4;
    localparam logic [9:0] HIST_LAST_IDX = 10'h3ff;
    localparam logic [9:0] COUNT_LAST_IDX = 10'h003;
    localparam logic [9:0] FIRST_REG_SLOT = 10'h002;
    localparam logic [9:0] LAST_SLOT = 10'h172;
    localparam logic [9:0] SLOT_ORIENT = 10'h003;
    localparam logic [9:0] SLOT_IRQ = 10'h094;
    localparam logic [9:0] SLOT_TPM = 10'h098;
    localparam logic [9:0] SLOT_PROT = 10'h16a;
    localparam logic [10:0] POS_COUNT = 11'h400;
    localparam logic [10:0] POS_SLOTS = 11'h404;
    localparam logic [10:0] POS_ORIENT = 11'h405;
    localparam logic [10:0] POS_IRQ = 11'h496;
    localparam logic [10:0] POS_LAST = 11'h574;
    localparam logic [15:0] ADDR_FCOUNT = 16'h0005;
    localparam logic [15:0] ADDR_ORIENT = 16'h0101;
    localparam logic [15:0] ADDR_IRQ = 16'h03f5;
    localparam logic [15:0] ADDR_TPM = 16'h0600;
    localparam logic [15:0] ADDR_PROT = 16'h3380;
    localparam logic [7:0] PROT_UNLOCK = 8'ha5;
    localparam logic [1:0] ORIENT_RESET = 2'h0;
    localparam logic [7:0] IRQ_RESET = 8'h00;
    localparam logic [3:0] TPM_RESET = 4'h0;
    localparam logic [7:0] PROT_RESET = 8'h00;
    localparam logic [31:0] FCOUNT_RESET = 32'h0000_0000;
    localparam int START_LATENCY = 3;
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_HIST = 2'b01,
        PH_COUNT = 2'b10,
        PH_SLOTS = 2'b11
    } phase_t;
    typedef enum logic [1:0] {
        SRC_HIST = 2'b00,
        SRC_LOCAL = 2'b01,
        SRC_EXT = 2'b10
    } src_t;
endpackage : trailer_pkg
